/* verilog/rail_cfg_pkg.sv */
// Purpose: Constants for the rail configuration register slice
// Assumes: Byte-wide registers at their printed sub-addresses
// Notes: Constant list below
`default_nettype none
package rail_cfg_pkg;
   localparam logic [7:0] OFS_SWITCH_CFG = 8'h15;
   localparam logic [7:0] OFS_BUCK_ONE = 8'h16;
   localparam logic [7:0] OFS_BUCK_TWO = 8'h17;
   localparam logic [7:0] OFS_BUCK_THREE = 8'h18;
   localparam logic [7:0] OFS_BUCK_BOOST = 8'h19;
   localparam logic [7:0] OFS_RAMP = 8'h1A;
   localparam logic [7:0] RST_SWITCH_CFG = 8'h00;
   localparam logic [7:0] RST_BUCK_ONE = 8'h99;
   localparam logic [7:0] RST_BUCK_TWO = 8'h99;
   localparam logic [7:0] RST_BUCK_THREE = 8'h8C;
   localparam logic [7:0] RST_BUCK_BOOST = 8'hB2;
   localparam logic [7:0] RST_RAMP = 8'h06;
   localparam logic [7:0] MASK_SWITCH_CFG = 8'h3F;
   localparam logic [7:0] MASK_VOLTAGE = 8'hBF;
   localparam logic [7:0] MASK_RAMP = 8'hC7;
   localparam int BIT_PULSE_SKIP = 7;
   localparam int BIT_TRIGGER = 7;
   localparam int BIT_BYPASS = 6;
   localparam int CUT_LSB = 3;
   localparam int DISCHARGE_LSB = 0;
   localparam logic [2:0] RATE_IMMEDIATE = 3'h7;
   localparam int CLOCK_MHZ = 50;
   // Shortest dwell is 2.5 us; longer codes double it
   localparam int DWELL_MIN_NS = 2500;
   localparam int DWELL_MIN_CYCLES = (DWELL_MIN_NS * CLOCK_MHZ) / 1000;
   localparam int NUM_SWITCH = 3;
endpackage : rail_cfg_pkg
`default_nettype wire

/* verilog/voltage_ramper.sv */
// Purpose: Steps one buck output code toward its set-point
// Assumes: Tick is a one-cycle enable at the shortest dwell
// Notes: One code per dwell; rate 111b jumps at once
`timescale 1ns/1ns
`default_nettype none
module voltage_ramper
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_b,
   // Control
   input wire logic i_start,
   input wire logic i_tick,
   input wire logic [2:0] i_rate,
   input wire logic [5:0] i_target,
   input wire logic [5:0] i_reset_code,
   // Result
   output logic [5:0] o_code,
   output logic o_busy
);
   import rail_cfg_pkg::*;

   typedef struct packed {
      logic [5:0] code;
      logic [5:0] goal;
      logic busy;
      logic [6:0] dwell;
   } ramp_t;

   ramp_t cur_ff;
   ramp_t nxt_ff;
   logic [6:0] dwell_len;

   // Dwell in ticks: 64 at code 000b halving to 1 at 110b
   assign dwell_len = 7'(7'h40 >> i_rate);

   always_comb
   begin
      nxt_ff = cur_ff;
      if (i_start)
      begin
         nxt_ff.goal = i_target;
         nxt_ff.busy = 1'b1;
         nxt_ff.dwell = dwell_len;
         if (i_rate == RATE_IMMEDIATE)
         begin
            nxt_ff.code = i_target;
            nxt_ff.busy = 1'b0;
         end
      end
      else if (cur_ff.busy)
      begin
         if (cur_ff.code == cur_ff.goal)
            nxt_ff.busy = 1'b0;
         else if (i_rate == RATE_IMMEDIATE)
            nxt_ff.code = cur_ff.goal;
         else if (i_tick)
         begin
            if (cur_ff.dwell > 7'h01)
               nxt_ff.dwell = cur_ff.dwell - 7'h01;
            else
            begin
               nxt_ff.dwell = dwell_len;
               nxt_ff.code = (cur_ff.code < cur_ff.goal) ? cur_ff.code + 6'h01 : cur_ff.code - 6'h01;
            end
         end
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_rst_b)
      begin
         cur_ff.code <= i_reset_code;
         cur_ff.goal <= i_reset_code;
         cur_ff.busy <= 1'b0;
         cur_ff.dwell <= 7'h00;
      end
      else
         cur_ff <= nxt_ff;
   end

   assign o_code = cur_ff.code;
   assign o_busy = cur_ff.busy;
endmodule : voltage_ramper
`default_nettype wire

/* verilog/rail_config_regs.sv */
// Purpose: Register slice for switch protection, converter codes and ramp control
// Assumes: Byte register port already decoded from the serial bus, synchronous to clock
// Notes: Reads are registered, one cycle after the strobe
`timescale 1ns/1ns
`default_nettype none
module rail_config_regs
(
   // Clock and reset
   input wire logic I_CLOCK,
   input wire logic I_RST_B,
   // Register port
   input wire logic I_WR,
   input wire logic I_RD,
   input wire logic [7:0] I_ADDR,
   input wire logic [7:0] I_WDATA,
   output logic [7:0] O_RDATA,
   output logic O_RVALID,
   // Power-up defaults from the selection resistor
   input wire logic I_DEFAULT_SELECT_VALID,
   input wire logic [5:0] I_BUCK_THREE_DEFAULT,
   input wire logic [5:0] I_BUCK_BOOST_DEFAULT,
   // Load switch control
   input wire logic [rail_cfg_pkg::NUM_SWITCH-1:0] I_SWITCH_EN,
   input wire logic I_POWER_FAIL_OUT_N,
   output logic [rail_cfg_pkg::NUM_SWITCH-1:0] O_SWITCH_ON,
   output logic [rail_cfg_pkg::NUM_SWITCH-1:0] O_SWITCH_DISCHARGE,
   // Converter settings
   output logic [5:0] O_BUCK_ONE_CODE,
   output logic [5:0] O_BUCK_TWO_CODE,
   output logic [5:0] O_BUCK_THREE_CODE,
   output logic [5:0] O_BUCK_BOOST_CODE,
   output logic [3:0] O_PULSE_SKIP_EN,
   output logic O_RAMP_BUSY
);
   import rail_cfg_pkg::*;

   typedef struct packed {
      logic [7:0] sw_cfg;
      logic [7:0] buck_one;
      logic [7:0] buck_two;
      logic [7:0] buck_three;
      logic [7:0] buck_boost;
      logic [7:0] ramp;
      logic [7:0] rdata;
      logic rvalid;
      logic [6:0] tick_cnt;
      logic tick;
      logic load_pending;
      logic [NUM_SWITCH-1:0] sw_on;
      logic [NUM_SWITCH-1:0] sw_dis;
   } regs_t;

   regs_t cur_ff;
   regs_t nxt_ff;
   logic start_one;
   logic start_two;
   logic busy_one;
   logic busy_two;
   logic [5:0] code_one;
   logic [5:0] code_two;
   logic [7:0] rd_mux;

   always_comb
   begin
      nxt_ff = cur_ff;
      start_one = 1'b0;
      start_two = 1'b0;
      rd_mux = 8'h00;
      nxt_ff.rvalid = I_RD;
      // Shortest-dwell tick shared by both ramps
      nxt_ff.tick = 1'b0;
      if (cur_ff.tick_cnt == 7'(DWELL_MIN_CYCLES - 1))
      begin
         nxt_ff.tick_cnt = 7'h00;
         nxt_ff.tick = 1'b1;
      end
      else
         nxt_ff.tick_cnt = cur_ff.tick_cnt + 7'h01;
      // One cycle after release, take resistor-chosen defaults
      if (cur_ff.load_pending)
      begin
         nxt_ff.load_pending = 1'b0;
         if (I_DEFAULT_SELECT_VALID)
         begin
            nxt_ff.buck_three[5:0] = I_BUCK_THREE_DEFAULT;
            nxt_ff.buck_boost[5:0] = I_BUCK_BOOST_DEFAULT;
         end
      end
      // Trigger self-clears when both ramps have landed
      if (cur_ff.ramp[BIT_TRIGGER] && !busy_one && !busy_two && !start_one)
         nxt_ff.ramp[BIT_TRIGGER] = 1'b0;
      if (I_WR)
      begin
         unique case (I_ADDR)
            OFS_SWITCH_CFG: nxt_ff.sw_cfg = I_WDATA & MASK_SWITCH_CFG;
            OFS_BUCK_ONE:
            begin
               nxt_ff.buck_one = I_WDATA & MASK_VOLTAGE;
               start_one = cur_ff.ramp[BIT_BYPASS];
            end
            OFS_BUCK_TWO:
            begin
               nxt_ff.buck_two = I_WDATA & MASK_VOLTAGE;
               start_two = cur_ff.ramp[BIT_BYPASS];
            end
            OFS_BUCK_THREE: nxt_ff.buck_three = I_WDATA & MASK_VOLTAGE;
            OFS_BUCK_BOOST: nxt_ff.buck_boost = I_WDATA & MASK_VOLTAGE;
            OFS_RAMP:
            begin
               nxt_ff.ramp = I_WDATA & MASK_RAMP;
               start_one = I_WDATA[BIT_TRIGGER];
               start_two = I_WDATA[BIT_TRIGGER];
            end
            default: ;
         endcase
      end
      unique case (I_ADDR)
         OFS_SWITCH_CFG: rd_mux = cur_ff.sw_cfg;
         OFS_BUCK_ONE: rd_mux = cur_ff.buck_one;
         OFS_BUCK_TWO: rd_mux = cur_ff.buck_two;
         OFS_BUCK_THREE: rd_mux = cur_ff.buck_three;
         OFS_BUCK_BOOST: rd_mux = cur_ff.buck_boost;
         OFS_RAMP: rd_mux = cur_ff.ramp;
         default: rd_mux = 8'h00;
      endcase
      if (I_RD)
         nxt_ff.rdata = rd_mux;
      // Power-fail cut overrides the enable; discharge only while off
      for (int i = 0; i < NUM_SWITCH; i++)
      begin
         nxt_ff.sw_on[i] = I_SWITCH_EN[i] && !(cur_ff.sw_cfg[CUT_LSB + i] && !I_POWER_FAIL_OUT_N);
         nxt_ff.sw_dis[i] = cur_ff.sw_cfg[DISCHARGE_LSB + i] && !nxt_ff.sw_on[i];
      end
   end

   always_ff @(posedge I_CLOCK)
   begin
      if (!I_RST_B)
      begin
         cur_ff.sw_cfg <= RST_SWITCH_CFG;
         cur_ff.buck_one <= RST_BUCK_ONE;
         cur_ff.buck_two <= RST_BUCK_TWO;
         cur_ff.buck_three <= RST_BUCK_THREE;
         cur_ff.buck_boost <= RST_BUCK_BOOST;
         cur_ff.ramp <= RST_RAMP;
         cur_ff.rdata <= 8'h00;
         cur_ff.rvalid <= 1'b0;
         cur_ff.tick_cnt <= 7'h00;
         cur_ff.tick <= 1'b0;
         cur_ff.load_pending <= 1'b1;
         cur_ff.sw_on <= '0;
         cur_ff.sw_dis <= '0;
      end
      else
         cur_ff <= nxt_ff;
   end

   // Bucks one and two follow their set-points through the ramp engines
   voltage_ramper u_ramp_one
   (
      .i_clk(I_CLOCK),
      .i_rst_b(I_RST_B),
      .i_start(start_one),
      .i_tick(cur_ff.tick),
      // A rate written with the trigger applies to that same start
      .i_rate(nxt_ff.ramp[2:0]),
      .i_target(nxt_ff.buck_one[5:0]),
      .i_reset_code(RST_BUCK_ONE[5:0]),
      .o_code(code_one),
      .o_busy(busy_one)
   );

   voltage_ramper u_ramp_two
   (
      .i_clk(I_CLOCK),
      .i_rst_b(I_RST_B),
      .i_start(start_two),
      .i_tick(cur_ff.tick),
      .i_rate(nxt_ff.ramp[2:0]),
      .i_target(nxt_ff.buck_two[5:0]),
      .i_reset_code(RST_BUCK_TWO[5:0]),
      .o_code(code_two),
      .o_busy(busy_two)
   );

   assign O_RDATA = cur_ff.rdata;
   assign O_RVALID = cur_ff.rvalid;
   assign O_SWITCH_ON = cur_ff.sw_on;
   assign O_SWITCH_DISCHARGE = cur_ff.sw_dis;
   assign O_BUCK_ONE_CODE = code_one;
   assign O_BUCK_TWO_CODE = code_two;
   assign O_BUCK_THREE_CODE = cur_ff.buck_three[5:0];
   assign O_BUCK_BOOST_CODE = cur_ff.buck_boost[5:0];
   assign O_PULSE_SKIP_EN = {cur_ff.buck_boost[BIT_PULSE_SKIP], cur_ff.buck_three[BIT_PULSE_SKIP],
                             cur_ff.buck_two[BIT_PULSE_SKIP], cur_ff.buck_one[BIT_PULSE_SKIP]};
   assign O_RAMP_BUSY = busy_one | busy_two;
endmodule : rail_config_regs
`default_nettype wire

/* verification/rail_cfg_asserts.sv */
// Purpose: Port-level checks for the rail register slice
// Assumes: Bound to rail_config_regs, one clock domain
// Notes: Codes of the ramped bucks are left to the bench
`timescale 1ns/1ns
`default_nettype none
module rail_cfg_asserts
(
   // Clock and reset
   input wire logic I_CLOCK,
   input wire logic I_RST_B,
   // Register port
   input wire logic I_WR,
   input wire logic I_RD,
   input wire logic [7:0] I_ADDR,
   input wire logic [7:0] I_WDATA,
   input wire logic [7:0] O_RDATA,
   input wire logic O_RVALID,
   // Switches and rails
   input wire logic [2:0] I_SWITCH_EN,
   input wire logic I_POWER_FAIL_OUT_N,
   input wire logic [2:0] O_SWITCH_ON,
   input wire logic [2:0] O_SWITCH_DISCHARGE,
   input wire logic [5:0] O_BUCK_THREE_CODE
);
   import rail_cfg_pkg::*;
   logic [7:0] wdata_ff;
   always_ff @(posedge I_CLOCK) wdata_ff <= I_WDATA;
   default clocking @(posedge I_CLOCK); endclocking
   default disable iff (!I_RST_B);
   sequence wr_three;
      I_WR && I_ADDR == OFS_BUCK_THREE;
   endsequence
   chk_read_answer: assert property (I_RD |=> O_RVALID) else $error("read unanswered");
   chk_read_cause: assert property (O_RVALID |-> $past(I_RD)) else $error("stray read valid");
   chk_bit6_zero: assert property (O_RVALID && $past(I_ADDR) != OFS_RAMP |-> !O_RDATA[6])
      else $error("reserved bit set");
   chk_unmapped_zero: assert property (O_RVALID && ($past(I_ADDR) < 8'h15 || $past(I_ADDR) > 8'h1A)
      |-> O_RDATA == 8'h00) else $error("unmapped read nonzero");
   chk_switch_follow: assert property (I_POWER_FAIL_OUT_N |=> O_SWITCH_ON == $past(I_SWITCH_EN))
      else $error("switch not following enable");
   chk_switch_gated: assert property ((O_SWITCH_ON & ~$past(I_SWITCH_EN)) == 3'h0)
      else $error("switch on while disabled");
   chk_discharge_off: assert property ((O_SWITCH_DISCHARGE & O_SWITCH_ON) == 3'h0)
      else $error("discharge while on");
   chk_three_direct: assert property (wr_three |=> O_BUCK_THREE_CODE == wdata_ff[5:0])
      else $error("buck three code not direct");
endmodule : rail_cfg_asserts
bind rail_config_regs rail_cfg_asserts u_chk (.I_CLOCK(I_CLOCK), .I_RST_B(I_RST_B), .I_WR(I_WR), .I_RD(I_RD),
   .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .O_RDATA(O_RDATA), .O_RVALID(O_RVALID), .I_SWITCH_EN(I_SWITCH_EN),
   .I_POWER_FAIL_OUT_N(I_POWER_FAIL_OUT_N), .O_SWITCH_ON(O_SWITCH_ON),
   .O_SWITCH_DISCHARGE(O_SWITCH_DISCHARGE), .O_BUCK_THREE_CODE(O_BUCK_THREE_CODE));
`default_nettype wire

/* verification/rail_host.sv */
// Purpose: Host side of the byte register port
// Assumes: Strobes are one-cycle pulses taken on the rising edge
// Notes: Released lines carry inverted values, never the last one
`timescale 1ns/1ns
`default_nettype none
module rail_host
(
   // Clock
   input wire logic i_clk,
   // Read return
   input wire logic [7:0] i_rdata,
   input wire logic i_rvalid,
   // Requests
   output logic o_wr,
   output logic o_rd,
   output logic [7:0] o_addr,
   output logic [7:0] o_wdata
);
   import rail_cfg_pkg::*;
   initial
   begin
      o_wr = 1'b0;
      o_rd = 1'b0;
      o_addr = 8'h00;
      o_wdata = 8'h00;
   end
   // Boost codes above 34h are dropped without driving a strobe
   task wr(input logic [7:0] a, input logic [7:0] d);
      if (a == OFS_BUCK_BOOST && d[5:0] > 6'h34)
         return;
      @(posedge i_clk);
      #1;
      o_wr = 1'b1;
      o_addr = a;
      o_wdata = d;
      @(posedge i_clk);
      #1;
      o_wr = 1'b0;
      o_addr = ~a;
      o_wdata = ~d;
   endtask : wr
   task rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge i_clk);
      #1;
      o_rd = 1'b1;
      o_addr = a;
      @(posedge i_clk);
      #1;
      o_rd = 1'b0;
      o_addr = ~a;
      d = i_rvalid ? i_rdata : 8'hXX;
   endtask : rd
endmodule : rail_host
`default_nettype wire

/* verification/rail_config_regs_tb.sv */
// Purpose: Self-checking bench for the rail register slice
// Assumes: Host model drives the register port
// Notes: Ramp test uses the fastest stepped rate to stay short
`timescale 1ns/1ns
`default_nettype none
module rail_config_regs_tb;
   import rail_cfg_pkg::*;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic dsel = 1'b0;
   logic pf_n = 1'b1;
   logic [2:0] sw_en = 3'h0;
   logic wr, rd, rvalid, busy;
   logic [7:0] addr, wdata, rdata, d;
   logic [2:0] sw_on, sw_dis;
   logic [5:0] c1, c2, c3, c4;
   logic [3:0] pskip;
   int miscompares = 0;
   int checks = 0;
   always #10 clk = ~clk;
   rail_config_regs u_dut (.I_CLOCK(clk), .I_RST_B(rst_b), .I_WR(wr), .I_RD(rd), .I_ADDR(addr),
      .I_WDATA(wdata), .O_RDATA(rdata), .O_RVALID(rvalid), .I_DEFAULT_SELECT_VALID(dsel),
      .I_BUCK_THREE_DEFAULT(6'h05), .I_BUCK_BOOST_DEFAULT(6'h21), .I_SWITCH_EN(sw_en),
      .I_POWER_FAIL_OUT_N(pf_n), .O_SWITCH_ON(sw_on), .O_SWITCH_DISCHARGE(sw_dis), .O_BUCK_ONE_CODE(c1),
      .O_BUCK_TWO_CODE(c2), .O_BUCK_THREE_CODE(c3), .O_BUCK_BOOST_CODE(c4), .O_PULSE_SKIP_EN(pskip),
      .O_RAMP_BUSY(busy));
   rail_host u_host (.i_clk(clk), .i_rdata(rdata), .i_rvalid(rvalid), .o_wr(wr), .o_rd(rd), .o_addr(addr),
      .o_wdata(wdata));
   task check(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task print_verdict;
      if (miscompares == 0 && checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : print_verdict
   task do_reset(input logic sel);
      @(posedge clk);
      #1;
      rst_b = 1'b0;
      dsel = sel;
      repeat (3) @(posedge clk);
      #1;
      rst_b = 1'b1;
      @(posedge clk);
   endtask : do_reset
   task test_reset_values;
      logic [7:0] rv [6];
      rv = '{8'h00, 8'h99, 8'h99, 8'h8C, 8'hB2, 8'h06};
      for (int i = 0; i < 6; i++)
      begin
         u_host.rd(OFS_SWITCH_CFG + 8'(i), d);
         check(d, rv[i]);
      end
      check({c1, 2'h0}, 8'h64);
      check({c3, 2'h0}, 8'h30);
      check({c4, 2'h0}, 8'hC8);
   endtask : test_reset_values
   task test_reserved;
      logic [7:0] msk [5];
      msk = '{8'h3F, 8'hBF, 8'hBF, 8'hBF, 8'hBF};
      for (int i = 0; i < 5; i++)
      begin
         u_host.wr(OFS_SWITCH_CFG + 8'(i), 8'hF4);
         u_host.rd(OFS_SWITCH_CFG + 8'(i), d);
         check(d, 8'hF4 & msk[i]);
      end
      u_host.wr(OFS_RAMP, 8'h3F);
      u_host.rd(OFS_RAMP, d);
      check(d, 8'h07);
      u_host.wr(8'h1B, 8'hFF);
      u_host.rd(8'h1B, d);
      check(d, 8'h00);
      check({c1, 2'h0}, 8'h64);
   endtask : test_reserved
   task test_switch;
      u_host.wr(OFS_SWITCH_CFG, 8'h3F);
      sw_en = 3'h7;
      repeat (2) @(posedge clk);
      #1;
      check({2'h0, sw_on, sw_dis}, 8'h38);
      pf_n = 1'b0;
      repeat (2) @(posedge clk);
      #1;
      check({2'h0, sw_on, sw_dis}, 8'h07);
      u_host.wr(OFS_SWITCH_CFG, 8'h2A);
      #20;
      check({2'h0, sw_on, sw_dis}, 8'h10);
      sw_en = 3'h0;
      repeat (2) @(posedge clk);
      #1;
      check({2'h0, sw_on, sw_dis}, 8'h02);
   endtask : test_switch
   task test_ramp;
      int n;
      u_host.wr(OFS_BUCK_ONE, 8'h1C);
      u_host.wr(OFS_BUCK_TWO, 8'h1C);
      check({4'h0, pskip}, 8'h0C);
      u_host.wr(OFS_RAMP, 8'h86);
      n = 0;
      @(posedge clk);
      #1;
      check({7'h0, busy}, 8'h01);
      while (busy === 1'b1 && n < 2000)
      begin
         @(posedge clk);
         #1;
         n++;
      end
      // Three steps of 125 cycles each, the first step may start early
      check(8'(n > 240 && n < 600), 8'h01);
      check({2'h0, c1}, 8'h1C);
      check({2'h0, c2}, 8'h1C);
      u_host.rd(OFS_RAMP, d);
      check(d, 8'h06);
      u_host.wr(OFS_RAMP, 8'h47);
      u_host.wr(OFS_BUCK_TWO, 8'h10);
      repeat (3) @(posedge clk);
      #1;
      check({c2, c1[5:4]}, 8'h41);
   endtask : test_ramp
   task test_defaults;
      do_reset(1'b1);
      u_host.rd(OFS_BUCK_THREE, d);
      check(d, 8'h85);
      u_host.rd(OFS_BUCK_BOOST, d);
      check(d, 8'hA1);
   endtask : test_defaults
   initial
   begin
      do_reset(1'b0);
      test_reset_values();
      test_reserved();
      test_switch();
      test_ramp();
      test_defaults();
      print_verdict();
   end
   initial
   begin
      // The ramp wait dominates; this is ample margin
      #200000;
      miscompares++;
      print_verdict();
   end
endmodule : rail_config_regs_tb
`default_nettype wire
